// ===== brg_regs.v
// brg_regs.v - bridge status / bridge config register bank with pixel and audio control
// assumes: one 20 MHz ref_clk, synchronous active-high reset, nvm read port on ref_clk,
// strap pin asynchronous, pixel and register port signals on ref_clk
//
// Operation
// RULE1 - init-done bit sets only after whole sequence, always after config-complete.
// RULE2 - config-complete bit sets when automatic configuration finishes, before init-done.
// RULE3 - verify two's-complement checksum over last 128 nvm bytes; 1 means pass.
// RULE4 - packing field bits 5-4: 00 three, 01 2.25, 10 two bytes; 11 reserved.
// RULE5 - convert RGB pixels to 24-bit RGB; pass YCbCr and compressed unchanged.
// RULE6 - in independent 2:2 mode packing field steers only the selected port.
// RULE7 - TDM bit 2 serializes parallel I2S lines onto the first I2S data line.
// RULE8 - audio source bit 1: 0 disables audio, 1 selects I2S pins; resets 1.
// RULE9 - aux audio bit 0 enables extra 2-channel audio beside main I2S audio.
// RULE10 - reinit bit reloads nvm config, restores straps, self-clears at init end.
// RULE11 - writes to status register ignored; reserved bits read zero.
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "brg_defs.vh"

module brg_regs #(
  parameter NVM_AW    = 10,
  parameter NVM_BYTES = 1024
) (
  // clock and reset
  input  wire              ref_clk,
  input  wire              reset,
  // register port
  input  wire [7:0]        regAddr,
  input  wire [7:0]        regWrData,
  input  wire              regWrStrobe,
  input  wire              regRdStrobe,
  output reg  [7:0]        regRdData_ff,
  // nvm read port
  output wire [NVM_AW-1:0] nvmAddr,
  output wire              nvmRdEn,
  input  wire [7:0]        nvmRdData,
  // strap pin
  input  wire              strapSplitAudioPin,
  output reg               strapSplitAudio_ff,
  // pixel path
  input  wire              indepMode,
  input  wire              selPort,
  input  wire [1:0]        pixFormat,
  input  wire [23:0]       pixIn,
  input  wire              pixInValid,
  output reg  [23:0]       pixOut_ff,
  output reg               pixOutValid_ff,
  output reg  [1:0]        port0PixelPacking_ff,
  output reg  [1:0]        port1PixelPackingSelect_ff,
  // i2s audio
  input  wire [3:0]        i2sDataIn,
  input  wire              i2sSlotTick,
  output reg               i2sDataOutA_ff,
  output reg  [2:0]        i2sDataOutBcd_ff,
  output reg               audioEnable_ff,
  output reg               auxAudioEnable_ff,
  output reg               tdmEnable_ff,
  // status mirrors
  output reg               initDone_ff,
  output reg               reinitBusy_ff
);

  // sequencer results
  wire             seqBusy;
  wire             seqCfgLoad;
  wire [7:0]       seqCfgData;
  wire             seqCfgDone;
  wire             seqInitDone;
  wire             seqCksumPass;

  // register state
  reg  [7:0]       bridgeConfig_ff;
  reg  [7:0]       nxt_bridgeConfig;
  reg              reinit_ff;
  reg              bootPend_ff;
  reg              seqStart_ff;
  reg              seqInitDoneD_ff;
  reg              strapMeta_ff;
  reg              strapSync_ff;
  reg  [1:0]       tdmSlot_ff;

  // read path
  reg  [7:0]       nxt_rdData;
  wire [7:0]       bridgeStatus;

  // pixel conversion
  reg  [23:0]      nxt_pix;

  wire [1:0]       packField;
  wire             cfgWrite;
  wire             reinitWrite;
  wire             seqDonePulse;

  brg_init_seq #(
    .AW        (NVM_AW),
    .NVM_BYTES (NVM_BYTES)
  ) u_init_seq (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .start        (seqStart_ff),
    .busy         (seqBusy),
    .nvmAddr_ff   (nvmAddr),
    .nvmRdEn_ff   (nvmRdEn),
    .nvmRdData    (nvmRdData),
    .cfgLoad_ff   (seqCfgLoad),
    .cfgData_ff   (seqCfgData),
    .cfgDone_ff   (seqCfgDone),
    .initDone_ff  (seqInitDone),
    .cksumPass_ff (seqCksumPass)
  );

  assign cfgWrite     = regWrStrobe && (regAddr == `BRG_CONFIG_OFS);
  assign reinitWrite  = regWrStrobe && (regAddr == `BRG_REINIT_CTRL_OFS) && regWrData[`BRG_REINIT_BIT];
  assign seqDonePulse = seqInitDone && !seqInitDoneD_ff;
  assign packField    = bridgeConfig_ff[`BRG_CFG_PACK_HI:`BRG_CFG_PACK_LO];

  // status word: only the three documented flags, all else zero
  assign bridgeStatus = {3'h0, seqInitDone, 1'b0, seqCfgDone, seqCksumPass, 1'b0}; // [RULE1] [RULE2] [RULE3] [RULE11]

  // strap pin is asynchronous: two flops before use
  always @(posedge ref_clk) begin
    if (reset) begin
      strapMeta_ff <= 1'b0;
      strapSync_ff <= 1'b0;
    end else begin
      strapMeta_ff <= strapSplitAudioPin;
      strapSync_ff <= strapMeta_ff;
    end
  end

  // sequencer start: once after reset, then on each reinit request made while the sequencer is idle
  always @(posedge ref_clk) begin
    if (reset) begin
      bootPend_ff     <= 1'b1;
      seqStart_ff     <= 1'b0;
      seqInitDoneD_ff <= 1'b0;
      reinit_ff       <= 1'b0;
    end else begin
      bootPend_ff     <= 1'b0;
      seqInitDoneD_ff <= seqInitDone;
      // a request while a pass runs is served by that pass
      seqStart_ff     <= bootPend_ff || (reinitWrite && !seqBusy && !seqStart_ff); // [RULE10]
      if (reinitWrite) begin
        reinit_ff <= 1'b1;                 // [RULE10]
      end else if (seqDonePulse) begin
        reinit_ff <= 1'b0;                 // [RULE10]
      end
    end
  end

  // config register: nvm reload wins over a software write in the same cycle
  always @* begin
    nxt_bridgeConfig = bridgeConfig_ff;
    if (seqCfgLoad) begin
      nxt_bridgeConfig = seqCfgData & `BRG_CONFIG_WMASK;  // [RULE10]
    end else if (cfgWrite) begin
      nxt_bridgeConfig = regWrData & `BRG_CONFIG_WMASK;   // [RULE11]
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      bridgeConfig_ff    <= `BRG_CONFIG_RESET; // [RULE8]
      strapSplitAudio_ff <= 1'b0;
    end else begin
      bridgeConfig_ff <= nxt_bridgeConfig;
      if (seqCfgLoad) begin
        strapSplitAudio_ff <= strapSync_ff; // [RULE10]
      end
    end
  end

  // read mux; unmapped addresses and the status write path return nothing extra
  always @* begin
    nxt_rdData = 8'h00;
    case (regAddr)
      `BRG_STATUS_OFS:      nxt_rdData = bridgeStatus;
      `BRG_CONFIG_OFS:      nxt_rdData = bridgeConfig_ff;
      `BRG_REINIT_CTRL_OFS: nxt_rdData = {6'h00, reinit_ff, 1'b0};
      `BRG_AUDIO_CFG_OFS:   nxt_rdData = 8'h00;
      default:              nxt_rdData = 8'h00; // [RULE11]
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      regRdData_ff <= 8'h00;
    end else if (regRdStrobe) begin
      regRdData_ff <= nxt_rdData;
    end else begin
      regRdData_ff <= 8'h00;
    end
  end

  // status mirrors for the rest of the chip
  always @(posedge ref_clk) begin
    if (reset) begin
      initDone_ff   <= 1'b0;
      reinitBusy_ff <= 1'b0;
    end else begin
      initDone_ff   <= seqInitDone; // [RULE1]
      reinitBusy_ff <= reinit_ff;
    end
  end

  // packing selects; reserved code falls back to three bytes
  always @(posedge ref_clk) begin
    if (reset) begin
      port0PixelPacking_ff       <= `BRG_PACK_3B;
      port1PixelPackingSelect_ff <= `BRG_PACK_3B;
    end else if (!indepMode) begin
      port0PixelPacking_ff       <= (packField == `BRG_PACK_RSVD) ? `BRG_PACK_3B : packField; // [RULE4]
      port1PixelPackingSelect_ff <= (packField == `BRG_PACK_RSVD) ? `BRG_PACK_3B : packField; // [RULE4]
    end else if (selPort) begin
      port1PixelPackingSelect_ff <= (packField == `BRG_PACK_RSVD) ? `BRG_PACK_3B : packField; // [RULE6]
    end else begin
      port0PixelPacking_ff       <= (packField == `BRG_PACK_RSVD) ? `BRG_PACK_3B : packField; // [RULE6]
    end
  end

  // rgb widening replicates msbs so full scale stays full scale
  always @* begin
    nxt_pix = pixIn;
    case (pixFormat)
      `BRG_FMT_RGB565: begin
        nxt_pix = {pixIn[15:11], pixIn[15:13], pixIn[10:5], pixIn[10:9], pixIn[4:0], pixIn[4:2]}; // [RULE5]
      end
      `BRG_FMT_RGB666: begin
        nxt_pix = {pixIn[17:12], pixIn[17:16], pixIn[11:6], pixIn[11:10], pixIn[5:0], pixIn[5:4]}; // [RULE5]
      end
      `BRG_FMT_RGB888: begin
        nxt_pix = pixIn;
      end
      `BRG_FMT_PASS: begin
        nxt_pix = pixIn; // [RULE5]
      end
      default: begin
        nxt_pix = pixIn;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      pixOut_ff      <= 24'h000000;
      pixOutValid_ff <= 1'b0;
    end else begin
      pixOutValid_ff <= pixInValid;
      if (pixInValid) begin
        pixOut_ff <= nxt_pix;
      end
    end
  end

  // audio controls
  always @(posedge ref_clk) begin
    if (reset) begin
      audioEnable_ff    <= 1'b1;
      auxAudioEnable_ff <= 1'b0;
      tdmEnable_ff      <= 1'b0;
    end else begin
      audioEnable_ff    <= bridgeConfig_ff[`BRG_CFG_AUDIO_SRC];                                      // [RULE8]
      auxAudioEnable_ff <= bridgeConfig_ff[`BRG_CFG_AUX_AUDIO] && bridgeConfig_ff[`BRG_CFG_AUDIO_SRC]; // [RULE9]
      tdmEnable_ff      <= bridgeConfig_ff[`BRG_CFG_TDM];                                            // [RULE7]
    end
  end

  // tdm: one slot per tick, lane 0..3 in turn onto the first data line
  always @(posedge ref_clk) begin
    if (reset) begin
      tdmSlot_ff       <= 2'h0;
      i2sDataOutA_ff   <= 1'b0;
      i2sDataOutBcd_ff <= 3'h0;
    end else if (!bridgeConfig_ff[`BRG_CFG_AUDIO_SRC]) begin
      tdmSlot_ff       <= 2'h0;
      i2sDataOutA_ff   <= 1'b0; // [RULE8]
      i2sDataOutBcd_ff <= 3'h0;
    end else if (bridgeConfig_ff[`BRG_CFG_TDM]) begin
      i2sDataOutBcd_ff <= 3'h0;
      if (i2sSlotTick) begin
        i2sDataOutA_ff <= i2sDataIn[tdmSlot_ff]; // [RULE7]
        tdmSlot_ff     <= tdmSlot_ff + 2'h1;
      end
    end else begin
      tdmSlot_ff       <= 2'h0;
      i2sDataOutA_ff   <= i2sDataIn[0];
      i2sDataOutBcd_ff <= i2sDataIn[3:1];
    end
  end

endmodule
`default_nettype wire

// ===== brg_defs.vh
// brg_defs.vh - offsets, field positions, reset values and counts for the bridge status/config registers
// assumes: included by bare name from the bridge register bank and its init sequencer
`ifndef BRG_DEFS_VH
`define BRG_DEFS_VH

// register offsets (byte addresses on the 8-bit register port)
`define BRG_REINIT_CTRL_OFS   8'h01
`define BRG_STATUS_OFS        8'h50
`define BRG_CONFIG_OFS        8'h54
`define BRG_AUDIO_CFG_OFS     8'h55

// bridge_status fields
`define BRG_STS_INIT_DONE     4
`define BRG_STS_CFG_DONE      2
`define BRG_STS_CKSUM         1
`define BRG_STATUS_RESET      8'h02

// bridge_config fields
`define BRG_CFG_PACK_HI       5
`define BRG_CFG_PACK_LO       4
`define BRG_CFG_TDM           2
`define BRG_CFG_AUDIO_SRC     1
`define BRG_CFG_AUX_AUDIO     0
`define BRG_CONFIG_RESET      8'h02
`define BRG_CONFIG_WMASK      8'h37

// reinit control field
`define BRG_REINIT_BIT        1

// pixel packing codes
`define BRG_PACK_3B           2'h0
`define BRG_PACK_2P25B        2'h1
`define BRG_PACK_2B           2'h2
`define BRG_PACK_RSVD         2'h3

// input pixel format codes
`define BRG_FMT_RGB888        2'h0
`define BRG_FMT_RGB666        2'h1
`define BRG_FMT_RGB565        2'h2
`define BRG_FMT_PASS          2'h3

// non-volatile memory layout
`define BRG_NVM_CFG_ADDR      10'h000
`define BRG_NVM_SUM_BYTES     128
`define BRG_NVM_SUM_LAST      7'h7F

`endif

// ===== brg_init_seq.v
// brg_init_seq.v - power-up / reinit sequencer: configuration load, then checksum over the nvm tail
// assumes: synchronous nvm read port on ref_clk, data valid the cycle after a read enable
`timescale 1ns/10ps
`default_nettype none
`include "brg_defs.vh"

module brg_init_seq #(
  parameter AW        = 10,
  parameter NVM_BYTES = 1024
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          reset,
  // control
  input  wire          start,
  output wire          busy,
  // nvm read port
  output reg  [AW-1:0] nvmAddr_ff,
  output reg           nvmRdEn_ff,
  input  wire [7:0]    nvmRdData,
  // results
  output reg           cfgLoad_ff,
  output reg  [7:0]    cfgData_ff,
  output reg           cfgDone_ff,
  output reg           initDone_ff,
  output reg           cksumPass_ff
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_CFG  = 5'h02;
  localparam [4:0] ST_CFGW = 5'h04;
  localparam [4:0] ST_SUM  = 5'h08;
  localparam [4:0] ST_FIN  = 5'h10;
  localparam [31:0]   SUM_BASE_W = NVM_BYTES - `BRG_NVM_SUM_BYTES;
  localparam [AW-1:0] SUM_BASE   = SUM_BASE_W[AW-1:0];

  reg [4:0] state_ff;
  reg [7:0] sum_ff;
  reg [6:0] cnt_ff;
  reg       rdPend_ff;

  assign busy = (state_ff != ST_IDLE);

  always @(posedge ref_clk) begin
    if (reset) begin
      state_ff     <= ST_IDLE;
      nvmAddr_ff   <= {AW{1'b0}};
      nvmRdEn_ff   <= 1'b0;
      cfgLoad_ff   <= 1'b0;
      cfgData_ff   <= 8'h00;
      cfgDone_ff   <= 1'b0;
      initDone_ff  <= 1'b0;
      cksumPass_ff <= 1'b1;
      sum_ff       <= 8'h00;
      cnt_ff       <= 7'h00;
      rdPend_ff    <= 1'b0;
    end else begin
      cfgLoad_ff <= 1'b0;
      nvmRdEn_ff <= 1'b0;
      rdPend_ff  <= nvmRdEn_ff;
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            cfgDone_ff  <= 1'b0;
            initDone_ff <= 1'b0;
            nvmAddr_ff  <= `BRG_NVM_CFG_ADDR;
            nvmRdEn_ff  <= 1'b1;
            state_ff    <= ST_CFG;
          end
        end
        ST_CFG: begin
          state_ff <= ST_CFGW;
        end
        ST_CFGW: begin
          // configuration lands first, so done precedes init done [RULE2]
          cfgData_ff <= nvmRdData;
          cfgLoad_ff <= 1'b1;
          cfgDone_ff <= 1'b1; // [RULE2]
          nvmAddr_ff <= SUM_BASE;
          nvmRdEn_ff <= 1'b1;
          sum_ff     <= 8'h00;
          cnt_ff     <= 7'h00;
          state_ff   <= ST_SUM;
        end
        ST_SUM: begin
          if (rdPend_ff) begin
            sum_ff <= sum_ff + nvmRdData; // [RULE3]
          end
          if (cnt_ff != `BRG_NVM_SUM_LAST) begin
            nvmAddr_ff <= nvmAddr_ff + {{(AW-1){1'b0}}, 1'b1};
            nvmRdEn_ff <= 1'b1;
            cnt_ff     <= cnt_ff + 7'h01;
          end else begin
            state_ff <= ST_FIN;
          end
        end
        ST_FIN: begin
          if (rdPend_ff) begin
            sum_ff <= sum_ff + nvmRdData;
          end else if (!nvmRdEn_ff) begin
            // two's-complement sum of the tail is zero when intact
            cksumPass_ff <= (sum_ff == 8'h00); // [RULE3]
            initDone_ff  <= 1'b1;              // [RULE1]
            state_ff     <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== bscr_monitor.sv
// bscr_monitor.sv - port-level assertions for the bridge register bank
// assumes: bound to brg_regs, one ref_clk domain, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module bscr_monitor (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrStrobe,
  input wire logic        regRdStrobe,
  input wire logic [7:0]  regRdData_ff,
  // pixel path
  input wire logic [1:0]  pixFormat,
  input wire logic [23:0] pixIn,
  input wire logic        pixInValid,
  input wire logic [23:0] pixOut_ff,
  input wire logic        pixOutValid_ff,
  // audio and status
  input wire logic        audioEnable_ff,
  input wire logic        auxAudioEnable_ff,
  input wire logic        initDone_ff,
  input wire logic        reinitBusy_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_rd_idle_zero: assert property (!$past(regRdStrobe) |-> regRdData_ff == 8'h00)
    else $error("read data not zero outside its slot");
  a_sts_rsvd_zero: assert property ($past(regRdStrobe) && $past(regAddr) == 8'h50 |-> (regRdData_ff & 8'hE9) == 8'h00)
    else $error("status reserved bits not zero");
  a_cfg_rsvd_zero: assert property ($past(regRdStrobe) && $past(regAddr) == 8'h54 |-> (regRdData_ff & 8'hC8) == 8'h00)
    else $error("config reserved bits not zero");
  a_audio_src_follow: assert property (regWrStrobe && regAddr == 8'h54 |-> ##2 audioEnable_ff == (($past(regWrData, 2) & 8'h02) != 8'h00))
    else $error("audio enable does not follow config");
  a_aux_follow: assert property (regWrStrobe && regAddr == 8'h54 |-> ##2 auxAudioEnable_ff == (($past(regWrData, 2) & 8'h03) == 8'h03))
    else $error("aux audio does not follow config");
  a_aux_needs_src: assert property (auxAudioEnable_ff |-> audioEnable_ff)
    else $error("aux audio without audio source");
  a_pix_latency: assert property (pixInValid |=> pixOutValid_ff)
    else $error("pixel output missing");
  a_pix_no_extra: assert property (!pixInValid |=> !pixOutValid_ff)
    else $error("pixel output without input");
  a_pix_passthru: assert property (pixInValid && (pixFormat == 2'h0 || pixFormat == 2'h3) |=> pixOut_ff == $past(pixIn))
    else $error("pixel altered in pass-through format");
  a_reinit_end: assert property ($fell(reinitBusy_ff) |-> ##[0:2] initDone_ff)
    else $error("reinit cleared before init done");
endmodule
bind brg_regs bscr_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData_ff(regRdData_ff), .pixFormat(pixFormat),
  .pixIn(pixIn), .pixInValid(pixInValid), .pixOut_ff(pixOut_ff), .pixOutValid_ff(pixOutValid_ff),
  .audioEnable_ff(audioEnable_ff), .auxAudioEnable_ff(auxAudioEnable_ff), .initDone_ff(initDone_ff),
  .reinitBusy_ff(reinitBusy_ff));
`default_nettype wire

// ===== bridge_status_config_regs_tb.sv
// bridge_status_config_regs_tb.sv - self-checking bench for the bridge register bank
// assumes: brg_regs with a shrunk 256-byte nvm, modelled here with one-cycle read data
`timescale 1ns/10ps
`default_nettype none
module bridge_status_config_regs_tb;
  localparam NVM_BYTES = 256;
  logic        ref_clk, reset, regWrStrobe, regRdStrobe, strapSplitAudioPin;
  logic        indepMode, selPort, pixInValid, i2sSlotTick;
  logic [7:0]  regAddr, regWrData, nvmRdData;
  logic [1:0]  pixFormat;
  logic [23:0] pixIn;
  logic [3:0]  i2sDataIn;
  wire  [7:0]  regRdData_ff;
  wire  [9:0]  nvmAddr;
  wire  [23:0] pixOut_ff;
  wire  [1:0]  pack0, pack1;
  wire  [2:0]  i2sBcd;
  wire         nvmRdEn, strapOut, pixOutValid_ff, i2sA, audioEnable_ff, auxAudioEnable_ff;
  wire         tdmEnable_ff, initDone_ff, reinitBusy_ff;
  logic [7:0]  nvm [0:NVM_BYTES-1];
  logic [31:0] seed, bgSeed;
  int          miscompares, checks_done, cfgModel;

  brg_regs #(.NVM_BYTES(NVM_BYTES)) DUT (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData_ff(regRdData_ff),
    .nvmAddr(nvmAddr), .nvmRdEn(nvmRdEn), .nvmRdData(nvmRdData), .strapSplitAudioPin(strapSplitAudioPin),
    .strapSplitAudio_ff(strapOut), .indepMode(indepMode), .selPort(selPort), .pixFormat(pixFormat),
    .pixIn(pixIn), .pixInValid(pixInValid), .pixOut_ff(pixOut_ff), .pixOutValid_ff(pixOutValid_ff),
    .port0PixelPacking_ff(pack0), .port1PixelPackingSelect_ff(pack1), .i2sDataIn(i2sDataIn),
    .i2sSlotTick(i2sSlotTick), .i2sDataOutA_ff(i2sA), .i2sDataOutBcd_ff(i2sBcd),
    .audioEnable_ff(audioEnable_ff), .auxAudioEnable_ff(auxAudioEnable_ff), .tdmEnable_ff(tdmEnable_ff),
    .initDone_ff(initDone_ff), .reinitBusy_ff(reinitBusy_ff));

  always #25 ref_clk = ~ref_clk;

  // idle nvm lines toggle so stale data cannot pass for a real answer
  always @(posedge ref_clk) begin
    nvmRdData <= nvmRdEn ? nvm[nvmAddr[7:0]] : ~nvmRdData;
    bgSeed <= lfsr(bgSeed);
    i2sDataIn <= bgSeed[3:0];
    i2sSlotTick <= bgSeed[4];
    strapSplitAudioPin <= bgSeed[5];
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // upper half: mask of bits the conversion must carry, lower half: expected
  function automatic logic [47:0] pix_ref(input logic [1:0] f, input logic [23:0] p);
    case (f)
      2'h1: return {24'hFCFCFC, p[17:12], 2'h0, p[11:6], 2'h0, p[5:0], 2'h0};
      2'h2: return {24'hF8FCF8, p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
      default: return {24'hFFFFFF, p};
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    checks_done++;
    if (got !== expv) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1 d = regRdData_ff;
  endtask

  // tail sums to zero unless bad is set
  task automatic fill_nvm(input logic bad);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < NVM_BYTES; i++) begin
      seed = lfsr(seed);
      nvm[i] = seed[7:0];
      if (i >= NVM_BYTES - 128 && i < NVM_BYTES - 1) sum += nvm[i];
    end
    nvm[NVM_BYTES-1] = 8'h00 - sum + {7'h00, bad};
    cfgModel = nvm[0] & 8'h37;
  endtask

  task automatic wait_init;
    // let a just-started pass clear the old done flag before polling it
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 1000 && initDone_ff !== 1'b1; i++) @(posedge ref_clk);
    chk("initDone", 1, initDone_ff);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    wrap_up;
  end

  initial begin
    logic [7:0]  d;
    logic [7:0]  w;
    logic [47:0] r;
    logic [3:0]  l;
    ref_clk = 1'b0;
    reset = 1'b1;
    {regWrStrobe, regRdStrobe, indepMode, selPort, pixInValid} = 5'h00;
    {regAddr, regWrData, pixFormat, pixIn} = 42'h0;
    seed = 32'hF7C6F574;
    bgSeed = 32'hF7C6F574;
    fill_nvm(1'b0);
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h54, d);
    chk("config reset", 8'h02, d);
    wait_init;
    rd(8'h50, d);
    chk("status pass", 8'h16, d);
    rd(8'h54, d);
    chk("config load", cfgModel, d);
    wr(8'h50, 8'hFF);
    rd(8'h50, d);
    chk("status ro", 8'h16, d);
    rd(8'h55, d);
    chk("audio cfg", 8'h00, d);
    rd(8'h33, d);
    chk("unmapped", 8'h00, d);
    indepMode <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      w = {seed[7:6], k[1:0], seed[3:0]};
      selPort <= k[2];
      wr(8'h54, w);
      cfgModel = w & 8'h37;
      rd(8'h54, d);
      chk("config rw", cfgModel, d);
      chk("packing", k[1:0] == 2'h3 ? 2'h0 : k[1:0], k[2] ? pack1 : pack0);
      chk("audio src", w[1], audioEnable_ff);
      chk("tdm", w[2], tdmEnable_ff);
      chk("aux", w[0] & w[1], auxAudioEnable_ff);
    end
    wr(8'h54, 8'h02);
    repeat (2) @(posedge ref_clk);
    l = i2sDataIn;
    #1 chk("i2s lanes", l, {i2sBcd, i2sA});
    wr(8'h54, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk("i2s off", 4'h0, {i2sBcd, i2sA});
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      r = pix_ref(k[1:0], seed[23:0]);
      @(posedge ref_clk);
      pixFormat <= k[1:0];
      pixIn <= seed[23:0];
      pixInValid <= 1'b1;
      @(posedge ref_clk);
      pixInValid <= 1'b0;
      #1 chk("pixel", r[23:0], pixOut_ff & r[47:24]);
    end
    fill_nvm(1'b1);
    wr(8'h01, 8'h02);
    rd(8'h01, d);
    chk("reinit busy", 8'h02, d & 8'h02);
    wait_init;
    rd(8'h01, d);
    chk("reinit clear", 8'h00, d & 8'h02);
    rd(8'h50, d);
    chk("status fail", 8'h14, d);
    rd(8'h54, d);
    chk("config reload", cfgModel, d);
    wrap_up;
  end
endmodule
`default_nettype wire
